// [rtcct_defs.vh]
// Behaviour
// - match interrupt request raised only while match enable bit 1 is set
// - counter wraps to zero at wrap limit; wrap request needs enable bit 0
// - match flag, bit 1, set on a prescaled counting tick while counter equals match value
// - wrap flag, bit 0, set when counter reaches wrap limit and returns to zero
// - writing one clears a flag; writing zero leaves it unchanged
// - one 8-bit read/write byte latch shared by all 16-bit registers
// - halted processor stops counter unless run-in-halt bit is one
// - two-bit source choice selects one of four counting clock sources
// - 16-bit registers: low byte at base offset, high byte at base plus one
// - counter write lands two counting ticks later, busy meanwhile; reset zero
// - wrap limit resets to all ones; update lands two ticks later, busy meanwhile
// - match value is 16-bit read/write, resets to zero, two byte halves
// - interval code 6:3 picks 4 to 32768 tick spacing; 0 and 0xF give none
// - tick timer runs only while tick enable bit 0 is set
// - tick busy bit 0 reads one while tick control write is synchronising
// - prescaler divides counting clock by powers of two, changes land two ticks later
// - tick flag set on each periodic event, cleared by writing one
// - counter enable bit 0 of control A enables the counter
`ifndef RTCCT_DEFS_VH
`define RTCCT_DEFS_VH

// register indices; byte address is four times the index
`define RTCCT_IDX_CTRLA 5'h00
`define RTCCT_IDX_STATUS 5'h01
`define RTCCT_IDX_IRQ_EN 5'h02
`define RTCCT_IDX_IRQ_FLAGS 5'h03
`define RTCCT_IDX_LATCH 5'h04
`define RTCCT_IDX_HALT 5'h05
`define RTCCT_IDX_SOURCE 5'h07
`define RTCCT_IDX_CNT_L 5'h08
`define RTCCT_IDX_CNT_H 5'h09
`define RTCCT_IDX_WRAP_L 5'h0A
`define RTCCT_IDX_WRAP_H 5'h0B
`define RTCCT_IDX_MATCH_L 5'h0C
`define RTCCT_IDX_MATCH_H 5'h0D
`define RTCCT_IDX_TICK_CTL 5'h10
`define RTCCT_IDX_TICK_STAT 5'h11
`define RTCCT_IDX_TICK_IRQ_EN 5'h12
`define RTCCT_IDX_TICK_FLAGS 5'h13
`define RTCCT_IDX_TICK_HALT 5'h15

// field positions
`define RTCCT_BIT_WRAP 0
`define RTCCT_BIT_MATCH 1
`define RTCCT_BIT_ENABLE 0
`define RTCCT_BIT_RUN_IN_HALT 0
`define RTCCT_BIT_TICK_IRQ 0
`define RTCCT_PRESC_HI 6
`define RTCCT_PRESC_LO 3
`define RTCCT_INTERVAL_HI 6
`define RTCCT_INTERVAL_LO 3

// writable bit masks
`define RTCCT_CTRLA_MASK 8'hF9
`define RTCCT_TICK_CTL_MASK 8'h79

// reset values
`define RTCCT_RST_BYTE 8'h00
`define RTCCT_RST_CNT 16'h0000
`define RTCCT_RST_WRAP 16'hFFFF
`define RTCCT_RST_MATCH 16'h0000

// interval codes and crossing latency in counting ticks
`define RTCCT_INTERVAL_OFF 4'h0
`define RTCCT_INTERVAL_RSVD 4'hF
`define RTCCT_SYNC_TICKS 2'h2

`endif

// [rtcct_flag.v]
`timescale 1ns/100ps
`default_nettype none
module rtcct_flag (
  input wire pclk, // main clock
  input wire presetn, // async reset, active low
  input wire set, // hardware event pulse
  input wire clr, // software write-one clear
  output wire flag // sticky flag
);
  reg flag_reg;

  // set beats clear so an event in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (set) begin
      flag_reg <= 1'b1;
    end else if (clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;
endmodule
`default_nettype wire

// [rtcct_sync_stage.v]
`timescale 1ns/100ps
`default_nettype none
`include "rtcct_defs.vh"
module rtcct_sync_stage #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire pclk, // main clock
  input wire presetn, // async reset, active low
  input wire load, // software write pulse
  input wire [W-1:0] load_data, // written value
  input wire rtc_tick, // one pulse per counting clock cycle
  output wire busy, // update still in flight
  output wire apply, // pulse when the update lands
  output wire [W-1:0] value // effective value
);
  reg [W-1:0] pend_reg;
  reg [W-1:0] value_reg;
  reg [1:0] stage_reg;
  reg apply_reg;

  // a second write while busy restarts the wait with the newer value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= {W{1'b0}};
      value_reg <= RST;
      stage_reg <= 2'h0;
      apply_reg <= 1'b0;
    end else begin
      apply_reg <= 1'b0;
      if (load) begin
        pend_reg <= load_data;
        stage_reg <= `RTCCT_SYNC_TICKS;
      end else if (rtc_tick && stage_reg != 2'h0) begin
        stage_reg <= stage_reg - 2'h1;
        if (stage_reg == 2'h1) begin
          value_reg <= pend_reg;
          apply_reg <= 1'b1;
        end
      end
    end
  end

  assign busy = (stage_reg != 2'h0);
  assign apply = apply_reg;
  assign value = value_reg;
endmodule
`default_nettype wire

// [rtcct_top.v]
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "rtcct_defs.vh"
module rtcct_top (
  input wire pclk, // main clock, 250 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  input wire internal_fast_tick, // source 0 tick pulse
  input wire internal_slow_tick, // source 1 tick pulse
  input wire crystal_source, // source 2 tick pulse
  input wire external_clock_pin, // source 3 tick pulse
  input wire cpu_halted, // processor in break debug
  output wire irq // level interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire [4:0] idx;
  wire setup;
  wire access;
  wire wr;
  wire [7:0] wbyte;
  reg mapped;

  assign idx = paddr[6:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && mapped;
  assign wbyte = pwdata[7:0];
  assign pready = access;
  assign pslverr = access && !mapped;

  always @* begin
    mapped = 1'b0;
    if (paddr[11:7] == 5'h00 && paddr[1:0] == 2'h0) begin
      case (idx)
        `RTCCT_IDX_CTRLA, `RTCCT_IDX_STATUS, `RTCCT_IDX_IRQ_EN,
        `RTCCT_IDX_IRQ_FLAGS, `RTCCT_IDX_LATCH, `RTCCT_IDX_HALT,
        `RTCCT_IDX_SOURCE, `RTCCT_IDX_CNT_L, `RTCCT_IDX_CNT_H,
        `RTCCT_IDX_WRAP_L, `RTCCT_IDX_WRAP_H, `RTCCT_IDX_MATCH_L,
        `RTCCT_IDX_MATCH_H, `RTCCT_IDX_TICK_CTL, `RTCCT_IDX_TICK_STAT,
        `RTCCT_IDX_TICK_IRQ_EN, `RTCCT_IDX_TICK_FLAGS,
        `RTCCT_IDX_TICK_HALT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain software registers
  reg [7:0] irq_en_reg;
  reg [7:0] latch_reg;
  reg [7:0] halt_reg;
  reg [7:0] source_reg;
  reg [7:0] tick_irq_en_reg;
  reg [7:0] tick_halt_reg;
  reg [7:0] rd_hi_reg;
  reg [7:0] rd_byte;
  reg [7:0] rd_hi;
  reg [31:0] prdata_reg;
  reg irq_reg;
  reg [15:0] cnt_reg;
  reg [14:0] pre_cnt_reg;
  reg [14:0] tick_cnt_reg;

  wire is_lo_write;
  wire lo_read;

  // low byte write parks in the latch until its high byte arrives
  assign is_lo_write = wr && (idx == `RTCCT_IDX_CNT_L || idx == `RTCCT_IDX_WRAP_L ||
    idx == `RTCCT_IDX_MATCH_L);
  // low byte read parks the matching high byte for the next access
  // unmapped reads must leave the latch alone
  assign lo_read = access && !pwrite && mapped && (idx == `RTCCT_IDX_CNT_L ||
    idx == `RTCCT_IDX_WRAP_L || idx == `RTCCT_IDX_MATCH_L);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= `RTCCT_RST_BYTE;
      latch_reg <= `RTCCT_RST_BYTE;
      halt_reg <= `RTCCT_RST_BYTE;
      source_reg <= `RTCCT_RST_BYTE;
      tick_irq_en_reg <= `RTCCT_RST_BYTE;
      tick_halt_reg <= `RTCCT_RST_BYTE;
    end else begin
      if (wr && idx == `RTCCT_IDX_IRQ_EN) begin
        irq_en_reg <= wbyte & 8'h03;
      end
      if (wr && idx == `RTCCT_IDX_HALT) begin
        halt_reg <= wbyte & 8'h01;
      end
      if (wr && idx == `RTCCT_IDX_SOURCE) begin
        source_reg <= wbyte & 8'h03;
      end
      if (wr && idx == `RTCCT_IDX_TICK_IRQ_EN) begin
        tick_irq_en_reg <= wbyte & 8'h01;
      end
      if (wr && idx == `RTCCT_IDX_TICK_HALT) begin
        tick_halt_reg <= wbyte & 8'h01;
      end
      if ((wr && idx == `RTCCT_IDX_LATCH) || is_lo_write) begin
        latch_reg <= wbyte;
      end else if (lo_read) begin
        latch_reg <= rd_hi_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting clock source and crossing stages
  reg rtc_tick;

  always @* begin
    case (source_reg[1:0])
      2'h0: rtc_tick = internal_fast_tick;
      2'h1: rtc_tick = internal_slow_tick;
      2'h2: rtc_tick = crystal_source;
      default: rtc_tick = external_clock_pin;
    endcase
  end

  wire ctrla_busy;
  wire cnt_busy;
  wire wrap_busy;
  wire match_busy;
  wire tick_ctl_busy;
  wire cnt_apply;
  wire [7:0] ctrla_eff;
  wire [15:0] cnt_load_val;
  wire [15:0] wrap_eff;
  wire [15:0] match_eff;
  wire [7:0] tick_ctl_eff;
  wire ctrla_load;
  wire cnt_load;
  wire wrap_load;
  wire match_load;
  wire tick_ctl_load;

  // a high byte write launches the 16-bit update with the parked low byte
  assign ctrla_load = wr && idx == `RTCCT_IDX_CTRLA;
  assign cnt_load = wr && idx == `RTCCT_IDX_CNT_H;
  assign wrap_load = wr && idx == `RTCCT_IDX_WRAP_H;
  assign match_load = wr && idx == `RTCCT_IDX_MATCH_H;
  assign tick_ctl_load = wr && idx == `RTCCT_IDX_TICK_CTL;

  // control A also needs two ticks before the prescaler sees it
  rtcct_sync_stage #(.W(8), .RST(`RTCCT_RST_BYTE)) u_ctrla (
    .pclk(pclk), .presetn(presetn),
    .load(ctrla_load),
    .load_data(wbyte & `RTCCT_CTRLA_MASK), .rtc_tick(rtc_tick),
    .busy(ctrla_busy), .apply(), .value(ctrla_eff));

  rtcct_sync_stage #(.W(16), .RST(`RTCCT_RST_CNT)) u_cnt (
    .pclk(pclk), .presetn(presetn),
    .load(cnt_load),
    .load_data({wbyte, latch_reg}), .rtc_tick(rtc_tick),
    .busy(cnt_busy), .apply(cnt_apply), .value(cnt_load_val));

  rtcct_sync_stage #(.W(16), .RST(`RTCCT_RST_WRAP)) u_wrap (
    .pclk(pclk), .presetn(presetn),
    .load(wrap_load),
    .load_data({wbyte, latch_reg}), .rtc_tick(rtc_tick),
    .busy(wrap_busy), .apply(), .value(wrap_eff));

  rtcct_sync_stage #(.W(16), .RST(`RTCCT_RST_MATCH)) u_match (
    .pclk(pclk), .presetn(presetn),
    .load(match_load),
    .load_data({wbyte, latch_reg}), .rtc_tick(rtc_tick),
    .busy(match_busy), .apply(), .value(match_eff));

  rtcct_sync_stage #(.W(8), .RST(`RTCCT_RST_BYTE)) u_tick_ctl (
    .pclk(pclk), .presetn(presetn),
    .load(tick_ctl_load),
    .load_data(wbyte & `RTCCT_TICK_CTL_MASK), .rtc_tick(rtc_tick),
    .busy(tick_ctl_busy), .apply(), .value(tick_ctl_eff));

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  wire [3:0] presc;
  wire [15:0] pre_full;
  wire [14:0] pre_mask;
  wire cnt_run;
  wire pre_tick;
  wire at_wrap;
  wire wrap_event;
  wire match_event;

  assign presc = ctrla_eff[`RTCCT_PRESC_HI:`RTCCT_PRESC_LO];
  assign pre_full = (16'h0001 << presc) - 16'h0001;
  assign pre_mask = pre_full[14:0];
  // debug halt freezes the prescaler too, so no tick is lost or gained
  assign cnt_run = ctrla_eff[`RTCCT_BIT_ENABLE] &&
    !(cpu_halted && !halt_reg[`RTCCT_BIT_RUN_IN_HALT]);
  assign pre_tick = rtc_tick && cnt_run &&
    ((pre_cnt_reg & pre_mask) == pre_mask);
  assign at_wrap = (cnt_reg == wrap_eff);
  assign wrap_event = pre_tick && !cnt_apply && at_wrap;
  assign match_event = pre_tick && !cnt_apply && (cnt_reg == match_eff);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 15'h0000;
      cnt_reg <= `RTCCT_RST_CNT;
    end else begin
      if (!ctrla_eff[`RTCCT_BIT_ENABLE]) begin
        pre_cnt_reg <= 15'h0000;
      end else if (rtc_tick && cnt_run) begin
        pre_cnt_reg <= pre_cnt_reg + 15'h0001;
      end
      if (cnt_apply) begin
        cnt_reg <= cnt_load_val;
      end else if (pre_tick) begin
        if (at_wrap) begin
          cnt_reg <= 16'h0000;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic tick timer
  wire [3:0] interval;
  wire [15:0] tick_full;
  wire [14:0] tick_mask;
  wire tick_run;
  wire tick_event;

  assign interval = tick_ctl_eff[`RTCCT_INTERVAL_HI:`RTCCT_INTERVAL_LO];
  // code n spaces events by two to the power n+1 counting ticks
  assign tick_full = (16'h0002 << interval) - 16'h0001;
  assign tick_mask = tick_full[14:0];
  assign tick_run = tick_ctl_eff[`RTCCT_BIT_ENABLE] &&
    !(cpu_halted && !tick_halt_reg[`RTCCT_BIT_RUN_IN_HALT]);
  assign tick_event = rtc_tick && tick_run && interval != `RTCCT_INTERVAL_OFF &&
    interval != `RTCCT_INTERVAL_RSVD &&
    ((tick_cnt_reg & tick_mask) == tick_mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 15'h0000;
    end else if (!tick_ctl_eff[`RTCCT_BIT_ENABLE]) begin
      tick_cnt_reg <= 15'h0000;
    end else if (rtc_tick && tick_run) begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and interrupt
  wire wrap_flag;
  wire match_flag;
  wire tick_flag;
  wire flags_wr;
  wire tick_flags_wr;

  assign flags_wr = wr && idx == `RTCCT_IDX_IRQ_FLAGS;
  assign tick_flags_wr = wr && idx == `RTCCT_IDX_TICK_FLAGS;

  rtcct_flag u_wrap_flag (
    .pclk(pclk), .presetn(presetn), .set(wrap_event),
    .clr(flags_wr && wbyte[`RTCCT_BIT_WRAP]), .flag(wrap_flag));

  rtcct_flag u_match_flag (
    .pclk(pclk), .presetn(presetn), .set(match_event),
    .clr(flags_wr && wbyte[`RTCCT_BIT_MATCH]), .flag(match_flag));

  rtcct_flag u_tick_flag (
    .pclk(pclk), .presetn(presetn), .set(tick_event),
    .clr(tick_flags_wr && wbyte[`RTCCT_BIT_TICK_IRQ]), .flag(tick_flag));

  // one request per source, merged into the single level output
  wire match_irq;
  wire wrap_irq;
  wire tick_irq;

  assign match_irq = match_flag && irq_en_reg[`RTCCT_BIT_MATCH];
  assign wrap_irq = wrap_flag && irq_en_reg[`RTCCT_BIT_WRAP];
  assign tick_irq = tick_flag && tick_irq_en_reg[`RTCCT_BIT_TICK_IRQ];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= match_irq || wrap_irq || tick_irq;
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read path, captured in the setup cycle
  always @* begin
    rd_byte = 8'h00;
    rd_hi = 8'h00;
    case (idx)
      `RTCCT_IDX_CTRLA: rd_byte = ctrla_eff;
      `RTCCT_IDX_STATUS: rd_byte = {4'h0, match_busy, wrap_busy, cnt_busy, ctrla_busy};
      `RTCCT_IDX_IRQ_EN: rd_byte = irq_en_reg;
      `RTCCT_IDX_IRQ_FLAGS: rd_byte = {6'h00, match_flag, wrap_flag};
      `RTCCT_IDX_LATCH: rd_byte = latch_reg;
      `RTCCT_IDX_HALT: rd_byte = halt_reg;
      `RTCCT_IDX_SOURCE: rd_byte = source_reg;
      `RTCCT_IDX_CNT_L: begin
        rd_byte = cnt_reg[7:0];
        rd_hi = cnt_reg[15:8];
      end
      `RTCCT_IDX_WRAP_L: begin
        rd_byte = wrap_eff[7:0];
        rd_hi = wrap_eff[15:8];
      end
      `RTCCT_IDX_MATCH_L: begin
        rd_byte = match_eff[7:0];
        rd_hi = match_eff[15:8];
      end
      // high bytes come from the latch so both halves match one snapshot
      `RTCCT_IDX_CNT_H, `RTCCT_IDX_WRAP_H, `RTCCT_IDX_MATCH_H: rd_byte = latch_reg;
      `RTCCT_IDX_TICK_CTL: rd_byte = tick_ctl_eff;
      `RTCCT_IDX_TICK_STAT: rd_byte = {7'h00, tick_ctl_busy};
      `RTCCT_IDX_TICK_IRQ_EN: rd_byte = tick_irq_en_reg;
      `RTCCT_IDX_TICK_FLAGS: rd_byte = {7'h00, tick_flag};
      `RTCCT_IDX_TICK_HALT: rd_byte = tick_halt_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      rd_hi_reg <= 8'h00;
    end else if (setup) begin
      prdata_reg <= {24'h000000, (mapped ? rd_byte : 8'h00)};
      rd_hi_reg <= rd_hi;
    end
  end

  assign prdata = prdata_reg;
endmodule
`default_nettype wire

// [rtcct_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtcct_defs.vh"
module rtcct_chk (
  input wire logic pclk, // main clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic irq // level interrupt
);
  wire acc = psel && penable;
  wire [4:0] idx = paddr[6:2];
  wire legal = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
  logic [1:0] en_reg;
  logic ten_reg;
  // shadow of the two enable registers, only the bus writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 2'h0;
      ten_reg <= 1'b0;
    end else if (acc && pwrite && legal) begin
      if (idx == `RTCCT_IDX_IRQ_EN) en_reg <= pwdata[1:0];
      if (idx == `RTCCT_IDX_TICK_IRQ_EN) ten_reg <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_latch;
    acc && pwrite && legal && idx == `RTCCT_IDX_LATCH;
  endsequence
  sequence rd_latch;
    psel && !penable && !pwrite && legal && idx == `RTCCT_IDX_LATCH ##1 acc;
  endsequence
  ready_access_a: assert property (acc |-> pready) else $error("no pready in access");
  ready_idle_a: assert property (!acc |-> !pready) else $error("pready outside access");
  err_unmapped_a: assert property (acc && (!legal || idx == 5'h06 || idx == 5'h0E) |-> pslverr)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (acc && legal && idx inside {5'h02, 5'h03, 5'h04, 5'h08, 5'h0C}
    |-> !pslverr) else $error("error on mapped address");
  rdata_upper_a: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits set");
  rdata_hold_a: assert property (acc ##1 !psel |-> $stable(prdata)) else $error("read data moved");
  latch_back_a: assert property (wr_latch ##1 !psel ##1 rd_latch |->
    prdata[7:0] == $past(pwdata[7:0], 3)) else $error("latch read-back differs");
  irq_mask_a: assert property ((en_reg == 2'h0 && !ten_reg)[*2] |-> !irq)
    else $error("irq with all enables off");
endmodule
bind rtcct_top rtcct_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtcct_defs.vh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, cpu_halted, lerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  logic [3:0] src, src_mask, code;
  logic [1:0] gap;
  logic [15:0] a, b, c, w;
  int err_count, n_tests, s, seed;
  logic [4:0] ri [12] = '{5'h02, 5'h03, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h10, 5'h11};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00};
  rtcct_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_fast_tick(src[0]), .internal_slow_tick(src[1]),
    .crystal_source(src[2]), .external_clock_pin(src[3]), .cpu_halted(cpu_halted), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // one pulse every fourth clock on each source left on
  always @(posedge pclk) begin
    gap <= gap + 2'h1;
    src <= (gap == 2'h0) ? src_mask : 4'h0;
  end
  function automatic logic tick_fires(input logic [3:0] cd, input logic en);
    return en && cd != 4'h0 && cd != 4'hF;
  endfunction
  function automatic logic in_span(input logic [15:0] d, input logic [15:0] lo,
    input logic [15:0] hi);
    return d >= lo && d <= hi;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] ad, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= ad;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    chk(k, 33'h1, "zero wait states");
    rdat = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    apb(1'b1, {5'h00, i, 2'h0}, d);
  endtask
  task automatic rd(input logic [4:0] i);
    apb(1'b0, {5'h00, i, 2'h0}, 8'h00);
  endtask
  // low byte first: its read snapshots the high byte into the latch
  task automatic rd16(input logic [4:0] i, output logic [15:0] v);
    rd(i);
    v[7:0] = rdat[7:0];
    rd(i + 5'h01);
    v[15:8] = rdat[7:0];
  endtask
  task automatic wr16(input logic [4:0] i, input logic [15:0] v);
    wr(i, v[7:0]);
    wr(i + 5'h01, v[15:8]);
  endtask
  task automatic settle();
    int k;
    for (k = 0; k < 100; k++) begin
      rd(`RTCCT_IDX_STATUS);
      if (rdat[3:0] == 4'h0) begin
        rd(`RTCCT_IDX_TICK_STAT);
        if (rdat[0] == 1'b0) break;
      end
    end
    chk(k < 100, 1'b1, "busy stuck");
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, cpu_halted, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_mask = 4'h0;
    gap = 2'h0;
    seed = $urandom(32'hB4877A42);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`RTCCT_IDX_LATCH);
    chk(rdat, 32'h0, "latch reset");
    for (s = 0; s < 12; s++) begin
      rd(ri[s]);
      chk(rdat, rv[s], "reset value");
    end
    $display("test reset values done");
    repeat (3) begin
      code = $urandom;
      w = $urandom;
      wr(`RTCCT_IDX_LATCH, w[7:0]);
      rd(`RTCCT_IDX_LATCH);
      chk(rdat, w[7:0], "latch rw");
    end
    apb(1'b0, 12'h011, 8'h00);
    chk({lerr, rdat}, 33'h100000000, "misaligned read");
    apb(1'b1, 12'h018, 8'h5A);
    chk(lerr, 1'b1, "reserved write");
    wr(`RTCCT_IDX_TICK_STAT, 8'hFF);
    rd(`RTCCT_IDX_TICK_STAT);
    chk({lerr, rdat}, 33'h0, "read-only write");
    $display("test bus done");
    wr(`RTCCT_IDX_CTRLA, 8'h01);
    src_mask <= 4'hF;
    settle();
    for (s = 0; s < 4; s++) begin
      wr(`RTCCT_IDX_SOURCE, s[7:0]);
      src_mask <= ~(4'h1 << s);
      idle(6);
      rd16(`RTCCT_IDX_CNT_L, a);
      idle(40);
      rd16(`RTCCT_IDX_CNT_L, b);
      chk(b, a, "count on other source");
      src_mask <= 4'h1 << s;
      idle(40);
      rd16(`RTCCT_IDX_CNT_L, c);
      chk(c != b, 1'b1, "count on chosen source");
    end
    wr(`RTCCT_IDX_SOURCE, 8'h00);
    src_mask <= 4'h1;
    cpu_halted <= 1'b1;
    idle(6);
    rd16(`RTCCT_IDX_CNT_L, a);
    idle(40);
    rd16(`RTCCT_IDX_CNT_L, b);
    chk(b, a, "halted count");
    wr(`RTCCT_IDX_HALT, 8'h01);
    idle(40);
    rd16(`RTCCT_IDX_CNT_L, c);
    chk(c != b, 1'b1, "run in halt");
    cpu_halted <= 1'b0;
    $display("test source and halt done");
    src_mask <= 4'h0;
    w = 16'h0003 + ($urandom % 4);
    wr16(`RTCCT_IDX_WRAP_L, w);
    wr16(`RTCCT_IDX_CNT_L, 16'h0000);
    rd(`RTCCT_IDX_STATUS);
    chk(rdat[2:1], 2'h3, "wrap and count busy");
    src_mask <= 4'h1;
    settle();
    wr(`RTCCT_IDX_IRQ_FLAGS, 8'h03);
    idle(80);
    src_mask <= 4'h0;
    idle(6);
    rd(`RTCCT_IDX_IRQ_FLAGS);
    chk(rdat, 32'h3, "wrap and match flags");
    rd16(`RTCCT_IDX_CNT_L, a);
    chk(a <= w, 1'b1, "count within limit");
    wr(`RTCCT_IDX_IRQ_EN, 8'h01);
    idle(2);
    chk(irq, 1'b1, "wrap irq");
    wr(`RTCCT_IDX_IRQ_FLAGS, 8'h00);
    rd(`RTCCT_IDX_IRQ_FLAGS);
    chk(rdat, 32'h3, "zero write keeps");
    wr(`RTCCT_IDX_IRQ_FLAGS, 8'h01);
    rd(`RTCCT_IDX_IRQ_FLAGS);
    chk({irq, rdat}, 33'h2, "wrap flag cleared");
    wr(`RTCCT_IDX_IRQ_EN, 8'h02);
    idle(2);
    chk(irq, 1'b1, "match irq");
    wr(`RTCCT_IDX_IRQ_EN, 8'h00);
    idle(2);
    chk(irq, 1'b0, "match irq masked");
    wr(`RTCCT_IDX_IRQ_FLAGS, 8'h02);
    $display("test wrap and irq done");
    wr(`RTCCT_IDX_CTRLA, 8'h00);
    src_mask <= 4'h1;
    settle();
    src_mask <= 4'h0;
    w = $urandom;
    wr16(`RTCCT_IDX_CNT_L, w);
    rd(`RTCCT_IDX_STATUS);
    chk(rdat[1], 1'b1, "count busy");
    src_mask <= 4'h1;
    settle();
    rd16(`RTCCT_IDX_CNT_L, a);
    chk(a, w, "count landed");
    $display("test count write done");
    c = 16'h0001 + ($urandom % 3);
    code = 4'h2 + ($urandom % 2);
    src_mask <= 4'h0;
    wr16(`RTCCT_IDX_WRAP_L, 16'hFFFF);
    wr16(`RTCCT_IDX_MATCH_L, c);
    wr16(`RTCCT_IDX_CNT_L, 16'h0000);
    wr(`RTCCT_IDX_IRQ_FLAGS, 8'h03);
    wr(`RTCCT_IDX_CTRLA, {1'b0, code, 3'h1});
    rd(`RTCCT_IDX_STATUS);
    chk(rdat, 32'hF, "all busy");
    src_mask <= 4'h1;
    settle();
    rd16(`RTCCT_IDX_MATCH_L, a);
    chk(a, c, "match landed");
    rd16(`RTCCT_IDX_CNT_L, a);
    idle(160);
    rd16(`RTCCT_IDX_CNT_L, b);
    // 41 or 42 source ticks lie between the two snapshots
    w = 16'h0028 >> code;
    chk(in_span(b - a, w - 16'h0001, w + 16'h0002), 1'b1, "prescaled count");
    rd(`RTCCT_IDX_IRQ_FLAGS);
    chk(rdat, 32'h2, "match flag at value");
    $display("test prescaler and match done");
    wr(`RTCCT_IDX_TICK_IRQ_EN, 8'h01);
    for (s = 0; s < 4; s++) begin
      src_mask <= 4'h0;
      code = (s == 1) ? 4'h0 : (s == 2) ? 4'hF : 4'h1 + ($urandom % 4);
      wr(`RTCCT_IDX_TICK_CTL, {1'b0, code, 2'h0, s != 3});
      rd(`RTCCT_IDX_TICK_STAT);
      chk(rdat, 32'h1, "tick busy");
      src_mask <= 4'h1;
      settle();
      wr(`RTCCT_IDX_TICK_FLAGS, 8'h01);
      idle(180);
      rd(`RTCCT_IDX_TICK_FLAGS);
      chk(rdat[0], tick_fires(code, s != 3), "tick flag");
      chk(irq, tick_fires(code, s != 3), "tick irq");
    end
    $display("test tick timer done");
    wrap_up();
  end
endmodule
`default_nettype wire
